// >>> rtl/tsc_pkg.sv
// Package for the 64-bit timestamp counter.
// Assumes the core decodes system-register numbers before reaching this block.
package tsc_pkg;

    // ****************************************
    // System-register selection (regID within group selID)
    // ****************************************
    localparam logic [4:0] TSC_SEL_GROUP = 5'h0b;
    localparam logic [4:0] TSC_REG_LOW = 5'h00;
    localparam logic [4:0] TSC_REG_HIGH = 5'h01;
    localparam logic [4:0] TSC_REG_CTRL = 5'h02;
    localparam int TSC_EN_BIT = 0;

    // ****************************************
    // Reset values and counting constants
    // ****************************************
    localparam logic [31:0] TSC_HALF_RST = 32'h0000_0000;
    localparam logic TSC_EN_RST = 1'b0;
    localparam logic [31:0] TSC_ONE = 32'h0000_0001;
    // Last value of a half before it carries
    localparam logic [31:0] TSC_HALF_MAX = 32'hffff_ffff;

    typedef enum logic [1:0] {
        TSC_IDLE = 2'b01,
        TSC_RUN = 2'b10
    } tsc_mode_e;

    // Move-instruction request from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] reg_id;
        logic [4:0] sel_id;
        logic [31:0] wdata;
    } tsc_req_s;

    typedef struct packed {
        logic hit;
        logic [31:0] rdata;
    } tsc_rsp_s;

endpackage

// >>> rtl/tsc_half.sv
// One 32-bit half of the timestamp counter.
// Assumes the caller supplies the increment and the carry chain.
`timescale 1ns/1ps
module tsc_half
    import tsc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control
    input wire logic inc,
    input wire logic load,
    input wire logic [31:0] load_val,
    // State
    output logic [31:0] value,
    output logic carry
);

    typedef struct packed {
        logic [31:0] cnt;
    } tsc_half_s;

    tsc_half_s st_ff;
    tsc_half_s nxt_st;

    assign value = st_ff.cnt;
    assign carry = inc && (st_ff.cnt == TSC_HALF_MAX);

    always_comb begin
        nxt_st = st_ff;
        if (load) begin
            nxt_st.cnt = load_val;
        end else if (inc) begin
            nxt_st.cnt = st_ff.cnt + TSC_ONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_ff.cnt <= TSC_HALF_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

// >>> rtl/tsc_counter.sv
// Top of the 64-bit timestamp counter, a system-register slave of the core.
// Assumes one-cycle request strobes from the core's move-instruction unit.
`timescale 1ns/1ps
module tsc_counter
    import tsc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Core status, ignored on purpose
    input wire logic core_halted,
    // System-register move port
    input wire tsc_req_s req,
    output tsc_rsp_s rsp,
    // Status
    output logic count_enable_bit,
    output logic [63:0] count_value
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        tsc_mode_e mode;
        logic hit;
        logic [31:0] rdata;
    } tsc_top_s;

    tsc_top_s st_ff;
    tsc_top_s nxt_st;

    logic [31:0] low_val;
    logic [31:0] high_val;
    logic low_carry;
    logic running;
    logic sel_ok;
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;

    assign sel_ok = (req.sel_id == TSC_SEL_GROUP);
    assign wr_low = req.wr && sel_ok && (req.reg_id == TSC_REG_LOW);
    assign wr_high = req.wr && sel_ok && (req.reg_id == TSC_REG_HIGH);
    assign wr_ctrl = req.wr && sel_ok && (req.reg_id == TSC_REG_CTRL);

    // halt state does not stop it
    assign running = (st_ff.mode == TSC_RUN);

    // ****************************************
    // Counter halves
    // ****************************************
    // 64-bit count from two halves
    // write simply wins over the count
    tsc_half u_low (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .inc(running),
        .load(wr_low),
        .load_val(req.wdata),
        .value(low_val),
        .carry(low_carry)
    );

    tsc_half u_high (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .inc(low_carry && !wr_low),
        .load(wr_high),
        .load_val(req.wdata),
        .value(high_val),
        .carry()
    );

    // ****************************************
    // Control and read path
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.hit = req.rd && sel_ok && (req.reg_id <= TSC_REG_CTRL);
        nxt_st.rdata = TSC_HALF_RST;
        if (wr_ctrl) begin
            nxt_st.mode = req.wdata[TSC_EN_BIT] ? TSC_RUN : TSC_IDLE;
        end
        if (req.rd && sel_ok) begin
            case (req.reg_id)
                TSC_REG_LOW: begin
                    nxt_st.rdata = low_val;
                end
                TSC_REG_HIGH: begin
                    nxt_st.rdata = high_val;
                end
                TSC_REG_CTRL: begin
                    nxt_st.rdata[TSC_EN_BIT] = running;
                end
                default: begin
                    nxt_st.rdata = TSC_HALF_RST;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_ff.mode <= TSC_IDLE;
            st_ff.hit <= 1'b0;
            st_ff.rdata <= TSC_HALF_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rsp.hit = st_ff.hit;
    assign rsp.rdata = st_ff.rdata;
    assign count_enable_bit = running;
    assign count_value = {high_val, low_val};

endmodule

// >>> tb/tsc_monitor.sv
// Checker for the timestamp counter ports.
// Assumes it is bound onto tsc_counter.
`timescale 1ns/1ps
module tsc_monitor
    import tsc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Requests
    input wire logic core_halted,
    input wire tsc_req_s req,
    // Results
    input wire tsc_rsp_s rsp,
    input wire logic count_enable_bit,
    input wire logic [63:0] count_value
);
    // ****
    // Properties
    // ****
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_rd(logic [4:0] r);
        req.rd && req.sel_id == TSC_SEL_GROUP && req.reg_id == r;
    endsequence
    sequence s_wr(logic [4:0] r);
        req.wr && req.sel_id == TSC_SEL_GROUP && req.reg_id == r;
    endsequence
    AST_RST: assert property (disable iff (1'b0)
        sys_rst |=> count_value == 64'h0 && !count_enable_bit) else $error("reset");
    AST_HOLD: assert property (!count_enable_bit && !req.wr |=> $stable(count_value))
        else $error("hold");
    AST_INC: assert property (count_enable_bit && !req.wr |=>
        count_value == $past(count_value) + 64'h1) else $error("inc");
    AST_HALT: assert property (core_halted && count_enable_bit && !req.wr |=>
        count_value != $past(count_value)) else $error("halt");
    AST_RDLO: assert property (s_rd(TSC_REG_LOW) |=>
        rsp.hit && rsp.rdata == $past(count_value[31:0])) else $error("rdlo");
    AST_RDHI: assert property (s_rd(TSC_REG_HIGH) |=>
        rsp.hit && rsp.rdata == $past(count_value[63:32])) else $error("rdhi");
    AST_WRLO: assert property (s_wr(TSC_REG_LOW) ##0 !count_enable_bit |=>
        count_value == {$past(count_value[63:32]), $past(req.wdata)}) else $error("wrlo");
    AST_EN: assert property (s_wr(TSC_REG_CTRL) |=>
        count_enable_bit == $past(req.wdata[TSC_EN_BIT])) else $error("en");
endmodule
bind tsc_counter tsc_monitor u_mon (.clk_sys, .sys_rst, .core_halted, .req, .rsp, .count_enable_bit, .count_value);

// >>> tb/tsc_counter_tb.sv
// Self-checking bench for the timestamp counter.
// Assumes tsc_monitor is bound onto the counter.
`timescale 1ns/1ps
module tsc_counter_tb
    import tsc_pkg::*;
;
    // ****
    // Drivers
    // ****
    logic clk_sys = 1'b0, sys_rst = 1'b1, core_halted = 1'b0;
    tsc_req_s req = '0;
    tsc_rsp_s rsp;
    logic count_enable_bit;
    logic [63:0] count_value;
    logic [31:0] q[$];
    logic [31:0] v;
    int n_errors = 0, checks_done = 0, seed = 32'haf75;
    tsc_counter DUT (.clk_sys, .sys_rst, .core_halted, .req, .rsp, .count_enable_bit, .count_value);
    initial forever #50 clk_sys = ~clk_sys;
    task automatic op(logic w, logic r, logic [4:0] id, logic [31:0] d);
        @(posedge clk_sys);
        req <= '{w, r, id, TSC_SEL_GROUP, d};
    endtask
    task automatic rd(logic [4:0] id, logic [31:0] e);
        q.push_back(e);
        op(1'b0, 1'b1, id, 32'h0);
    endtask
    task automatic chk(logic [31:0] e, logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR rdata expected %h seen %h", e, s);
        end
    endtask
    // Enabled for exactly m edges, then read back
    task automatic run(logic [31:0] hi, logic [31:0] lo, int m);
        op(1'b1, 1'b0, TSC_REG_LOW, lo);
        op(1'b1, 1'b0, TSC_REG_HIGH, hi);
        op(1'b1, 1'b0, TSC_REG_CTRL, 32'h1);
        repeat (m - 1) op(1'b0, 1'b0, TSC_REG_LOW, 32'h0);
        op(1'b1, 1'b0, TSC_REG_CTRL, 32'h0);
        {v, lo} = {hi, lo} + 64'(m);
        rd(TSC_REG_LOW, lo);
        rd(TSC_REG_HIGH, v);
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        if (rsp.hit === 1'b1) begin
            if (q.size() == 0) begin
                n_errors++;
                $display("ERROR hit expected 0 seen 1");
            end else begin
                chk(q.pop_front(), rsp.rdata);
            end
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(TSC_REG_HIGH, 32'h0);
        rd(TSC_REG_LOW, 32'h0);
        repeat (4) begin
            v = $random(seed);
            op(1'b1, 1'b0, TSC_REG_HIGH, v);
            op(1'b1, 1'b0, TSC_REG_LOW, ~v);
            rd(TSC_REG_HIGH, v);
            rd(TSC_REG_LOW, ~v);
        end
        op(1'b0, 1'b1, 5'h03, 32'h0);
        // Careful read of a running count: high, low, high
        v = $random(seed);
        op(1'b1, 1'b0, TSC_REG_LOW, 32'h0);
        op(1'b1, 1'b0, TSC_REG_HIGH, v);
        op(1'b1, 1'b0, TSC_REG_CTRL, 32'h1);
        rd(TSC_REG_HIGH, v);
        rd(TSC_REG_LOW, 32'h1);
        rd(TSC_REG_HIGH, v);
        op(1'b1, 1'b0, TSC_REG_CTRL, 32'h0);
        core_halted <= 1'b1;
        run(32'h5, 32'hffff_fffe, 4);
        run(32'hffff_ffff, 32'hffff_ffff, 1);
        core_halted <= 1'b0;
        rd(TSC_REG_CTRL, 32'h0);
        op(1'b0, 1'b0, TSC_REG_LOW, 32'h0);
        for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge clk_sys);
        if (q.size() > 0) begin
            n_errors++;
            $display("ERROR pending expected 0 seen %0d", q.size());
        end
        report_and_stop();
    end
endmodule
